// ===== design/scrs_top.sv
// reset sequencer: power-up, supply monitor, pin and clock-loss resets with cause flags
`timescale 1ns/1ns
module scrs_top #(
  parameter int unsigned POR_DLY_LO_CYC = scrs_pkg::POR_DLY_LO_CYC,
  parameter int unsigned POR_DLY_MID_CYC = scrs_pkg::POR_DLY_MID_CYC,
  parameter int unsigned POR_DLY_HI_CYC = scrs_pkg::POR_DLY_HI_CYC,
  parameter int unsigned DLY_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic por_ok_i,
  input wire logic trip_ok_i,
  input wire logic warn_ok_i,
  input wire logic rst_pin_i,
  input wire logic sysclk_i,
  input wire logic [1:0] por_dly_sel_i,
  input wire logic sleep_i,
  input wire logic suspend_i,
  input wire logic flash_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic core_rst_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic ram_invalid_o,
  output logic supply_warn_o,
  output logic [15:0] fetch_addr_o
);
  // synchronised pin and comparator levels
  logic [6:0] pins_s;
  logic por_s;
  logic trip_s;
  logic warn_s;
  logic pin_s;
  logic sclk_s;
  logic [1:0] dly_sel_s;
  // sequencer state
  scrs_pkg::scrs_state_type state_r;
  scrs_pkg::scrs_state_type state_nxt;
  // shared delay and pulse counter
  logic [DLY_W-1:0] cnt_r;
  logic [DLY_W-1:0] cnt_nxt;
  logic [DLY_W-1:0] dly_load;
  // monitor enable, monitor selection, clock-loss enable
  logic mon_en_r;
  logic mon_sel_r;
  logic mcd_en_r;
  // cause flags
  logic flag_pin_r;
  logic flag_por_r;
  logic flag_mcd_r;
  logic flag_ferr_r;
  // cause latched when entering the one-shot reset
  logic cause_mcd_r;
  // pin blanking after our own drive
  logic [2:0] blank_r;
  // read data and restart address
  logic [7:0] rdata_r;
  logic [15:0] fetch_r;
  // decoded requests and events
  logic sel_eff;
  logic fail_req;
  logic pin_req;
  logic mcd_to;
  logic mcd_run;
  logic ferr_req;
  logic drive;
  logic leave;
  logic leave_pwr;
  logic wr_cause;
  logic wr_ctl;
  logic [7:0] ctl_rd;
  logic [7:0] cause_rd;

  // pins and comparators cross into the clock domain
  scrs_sync #(
    .W(7),
    .RST_VAL(scrs_pkg::PIN_SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i({por_dly_sel_i, sysclk_i, rst_pin_i, warn_ok_i, trip_ok_i, por_ok_i}),
    .q_o(pins_s)
  );
  assign por_s = pins_s[0];
  assign trip_s = pins_s[1];
  assign warn_s = pins_s[2];
  assign pin_s = pins_s[3];
  assign sclk_s = pins_s[4];
  assign dly_sel_s = pins_s[6:5];

  assign mcd_run = mcd_en_r & ~sleep_i & ~suspend_i & ~core_rst_o;

  // clock-loss one-shot
  scrs_clkmon u_clkmon (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .en_i(mcd_run),
    .sclk_i(sclk_s),
    .timeout_o(mcd_to)
  );

  assign sel_eff = mon_sel_r & ~sleep_i;
  assign fail_req = mon_en_r & sel_eff & ~trip_s;
  // pin reset in every power mode
  assign pin_req = ~pin_s & (blank_r == 3'h0);
  assign ferr_req = flash_wr_i & ~mon_en_r;
  // states that pull the reset pin low
  // pull pin while powering
  assign drive = (state_r == scrs_pkg::ST_POWER) || (state_r == scrs_pkg::ST_DELAY)
    || (state_r == scrs_pkg::ST_FAIL);
  assign leave = (state_r != scrs_pkg::ST_RUN) && (state_nxt == scrs_pkg::ST_RUN);
  assign leave_pwr = leave && ((state_r == scrs_pkg::ST_DELAY) || (state_r == scrs_pkg::ST_FAIL));
  // register writes only while the core runs
  assign wr_cause = sfr_wr_i & ~core_rst_o & (sfr_addr_i == scrs_pkg::ADDR_RESET_CAUSE);
  assign wr_ctl = sfr_wr_i & ~core_rst_o & (sfr_addr_i == scrs_pkg::ADDR_SUPPLY_CTRL);
  // power-up delay picked by supply level
  assign dly_load = (dly_sel_s == 2'h0) ? DLY_W'(POR_DLY_LO_CYC - 1) :
    (dly_sel_s == 2'h1) ? DLY_W'(POR_DLY_MID_CYC - 1) : DLY_W'(POR_DLY_HI_CYC - 1);

  // next state; power loss overrides everything
  always_comb begin
    state_nxt = state_r;
    if (!por_s) begin
      state_nxt = scrs_pkg::ST_POWER;
    end else begin
      unique case (state_r)
        scrs_pkg::ST_POWER: state_nxt = scrs_pkg::ST_DELAY;
        scrs_pkg::ST_DELAY: begin
          if (cnt_r == '0) begin
            state_nxt = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_FAIL: begin
          if (trip_s) begin
            state_nxt = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_PIN: begin
          if (fail_req) begin
            state_nxt = scrs_pkg::ST_FAIL;
          end else if (pin_s) begin
            state_nxt = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_PULSE: begin
          if (fail_req) begin
            state_nxt = scrs_pkg::ST_FAIL;
          end else if (pin_req) begin
            state_nxt = scrs_pkg::ST_PIN;
          end else if (cnt_r == '0) begin
            state_nxt = scrs_pkg::ST_RUN;
          end
        end
        scrs_pkg::ST_RUN: begin
          if (fail_req) begin
            state_nxt = scrs_pkg::ST_FAIL;
          end else if (pin_req) begin
            state_nxt = scrs_pkg::ST_PIN;
          end else if (mcd_to || ferr_req) begin
            state_nxt = scrs_pkg::ST_PULSE;
          end
        end
        default: state_nxt = scrs_pkg::ST_POWER;
      endcase
    end
  end

  // counter loads on entry to delay or pulse, counts down inside
  always_comb begin
    cnt_nxt = cnt_r;
    if (state_nxt == scrs_pkg::ST_DELAY && state_r != scrs_pkg::ST_DELAY) begin
      cnt_nxt = dly_load;
    end else if (state_nxt == scrs_pkg::ST_PULSE && state_r != scrs_pkg::ST_PULSE) begin
      cnt_nxt = DLY_W'(scrs_pkg::RST_PULSE_CYC - 1);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - DLY_W'(1);
    end
  end

  // state, counter and pin blanking
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= scrs_pkg::ST_POWER;
      cnt_r <= '0;
      blank_r <= scrs_pkg::PIN_BLANK_CYC;
    end else if (ce_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      blank_r <= drive ? scrs_pkg::PIN_BLANK_CYC : blank_r - ((blank_r != 3'h0) ? 3'h1 : 3'h0);
    end
  end

  // monitor settings: power resets force them, other resets keep them
  // power resets restore monitor defaults; clock-loss enable restored only on power-up exit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mon_en_r <= scrs_pkg::MON_ON_RST;
      mon_sel_r <= scrs_pkg::MON_SEL_RST;
      mcd_en_r <= scrs_pkg::CLK_LOSS_EN_RST;
    end else if (ce_i) begin
      if (leave_pwr) begin
        mon_en_r <= scrs_pkg::MON_ON_RST;
        mon_sel_r <= scrs_pkg::MON_SEL_RST;
      end else begin
        mon_en_r <= wr_ctl ? sfr_wdata_i[scrs_pkg::CTL_MON_ON_BIT] : mon_en_r;
        mon_sel_r <= wr_cause ? sfr_wdata_i[scrs_pkg::RC_POWER_UP_BIT] : mon_sel_r;
      end
      // writing bit 2 sets the enable
      if (leave && state_r == scrs_pkg::ST_DELAY) begin
        mcd_en_r <= scrs_pkg::CLK_LOSS_EN_RST;
      end else if (wr_cause) begin
        mcd_en_r <= sfr_wdata_i[scrs_pkg::RC_CLOCK_LOSS_BIT];
      end
    end
  end

  // cause flags are rewritten on every exit from reset
  // power flag set, others cleared
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_pin_r <= 1'b0;
      flag_por_r <= 1'b1;
      flag_mcd_r <= 1'b0;
      flag_ferr_r <= 1'b0;
      cause_mcd_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == scrs_pkg::ST_RUN && state_nxt == scrs_pkg::ST_PULSE) begin
        cause_mcd_r <= mcd_to;
      end
      if (leave) begin
        flag_por_r <= leave_pwr;
        flag_pin_r <= (state_r == scrs_pkg::ST_PIN);
        flag_mcd_r <= (state_r == scrs_pkg::ST_PULSE) && cause_mcd_r;
        flag_ferr_r <= (state_r == scrs_pkg::ST_PULSE) && !cause_mcd_r;
      end
    end
  end

  // read images of the two registers
  // supply level bits read live
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[scrs_pkg::CTL_MON_ON_BIT] = mon_en_r;
    ctl_rd[scrs_pkg::CTL_ABOVE_TRIP_BIT] = trip_s;
    ctl_rd[scrs_pkg::CTL_ABOVE_WARN_BIT] = warn_s;
    cause_rd = 8'h00;
    cause_rd[scrs_pkg::RC_PIN_BIT] = flag_pin_r;
    cause_rd[scrs_pkg::RC_POWER_UP_BIT] = flag_por_r;
    cause_rd[scrs_pkg::RC_CLOCK_LOSS_BIT] = flag_mcd_r;
    cause_rd[scrs_pkg::RC_FLASH_ERR_BIT] = flag_ferr_r;
  end

  // registered read data and restart address
  // fixed restart address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
      fetch_r <= scrs_pkg::RESTART_ADDR;
    end else if (ce_i) begin
      rdata_r <= (sfr_addr_i == scrs_pkg::ADDR_SUPPLY_CTRL) ? ctl_rd :
        (sfr_addr_i == scrs_pkg::ADDR_RESET_CAUSE) ? cause_rd : 8'h00;
      fetch_r <= core_rst_o ? scrs_pkg::RESTART_ADDR : fetch_r;
    end
  end

  // outputs
  assign sfr_rdata_o = rdata_r;
  assign core_rst_o = (state_r != scrs_pkg::ST_RUN);
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_o = drive;
  assign ram_invalid_o = flag_por_r;
  // warning when at or below level
  assign supply_warn_o = ~warn_s;
  assign fetch_addr_o = fetch_r;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_power_drive: assert property (state_r == scrs_pkg::ST_POWER |-> rst_pin_oe_o && core_rst_o)
    else $error("pin not driven during power-up");
  a_delay_end: assert property (ce_i && por_s && state_r == scrs_pkg::ST_DELAY && cnt_r == '0
    |=> state_r == scrs_pkg::ST_RUN && !rst_pin_oe_o)
    else $error("power-up delay did not end at zero");
  a_por_flags: assert property (ce_i && leave && state_r == scrs_pkg::ST_DELAY
    |=> flag_por_r && !flag_pin_r && !flag_mcd_r && mon_en_r && mon_sel_r)
    else $error("power-up exit flags wrong");
  a_restart_addr: assert property ($fell(core_rst_o) |-> fetch_addr_o == scrs_pkg::RESTART_ADDR)
    else $error("restart address wrong");
  a_fail_entry: assert property (ce_i && por_s && state_r == scrs_pkg::ST_RUN && fail_req
    |=> state_r == scrs_pkg::ST_FAIL && rst_pin_oe_o ##0 core_rst_o)
    else $error("supply monitor reset not taken");
  a_sleep_mask: assert property (ce_i && sleep_i && state_r == scrs_pkg::ST_RUN
    |=> state_r != scrs_pkg::ST_FAIL)
    else $error("power-fail reset taken in sleep");
  a_flash_reset: assert property (ce_i && por_s && state_r == scrs_pkg::ST_RUN && !fail_req
    && !pin_req && ferr_req |=> state_r == scrs_pkg::ST_PULSE ##[1:20] flag_ferr_r)
    else $error("flash error reset missing");
  a_pin_flag: assert property (ce_i && state_r == scrs_pkg::ST_PIN && state_nxt == scrs_pkg::ST_RUN
    |=> flag_pin_r && !flag_por_r)
    else $error("pin flag not set");
  a_mcd_nopin: assert property (state_r == scrs_pkg::ST_PULSE |-> !rst_pin_oe_o)
    else $error("pin driven by one-shot reset");
  a_keep_mon: assert property (ce_i && state_r == scrs_pkg::ST_PIN |=> $stable(mon_en_r)
    && $stable(mon_sel_r))
    else $error("monitor settings changed by pin reset");
endmodule

// ===== include/scrs_pkg.sv
// constants, timing counts and state type for the reset-source block
package scrs_pkg;
  // system clock period
  localparam int unsigned CLK_PERIOD_NS = 100;
  // power-up release delays by supply level
  localparam int unsigned POR_DLY_LO_MS = 3;
  localparam int unsigned POR_DLY_MID_MS = 7;
  localparam int unsigned POR_DLY_HI_MS = 15;
  localparam int unsigned POR_DLY_LO_CYC = POR_DLY_LO_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned POR_DLY_MID_CYC = POR_DLY_MID_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned POR_DLY_HI_CYC = POR_DLY_HI_MS * 1000000 / CLK_PERIOD_NS;
  // clock-loss timeout, rounded up
  localparam int unsigned CLK_LOSS_US = 100;
  localparam int unsigned CLK_LOSS_CYC = (CLK_LOSS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // hold time of internal one-shot resets
  localparam int unsigned RST_PULSE_NS = 1000;
  localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // cycles the pin is ignored after our own drive ends
  localparam logic [2:0] PIN_BLANK_CYC = 3'h4;
  // register addresses
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hEF;
  localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'hFF;
  // supply_monitor_control fields
  localparam int unsigned CTL_MON_ON_BIT = 7;
  localparam int unsigned CTL_ABOVE_TRIP_BIT = 6;
  localparam int unsigned CTL_ABOVE_WARN_BIT = 5;
  // reset_cause_register fields
  localparam int unsigned RC_PIN_BIT = 0;
  localparam int unsigned RC_POWER_UP_BIT = 1;
  localparam int unsigned RC_CLOCK_LOSS_BIT = 2;
  localparam int unsigned RC_FLASH_ERR_BIT = 6;
  // reset values
  localparam logic MON_ON_RST = 1'b1;
  localparam logic MON_SEL_RST = 1'b1;
  localparam logic CLK_LOSS_EN_RST = 1'b0;
  localparam logic [15:0] RESTART_ADDR = 16'h0000;
  // synchroniser reset pattern: {dly_sel, sysclk, pin, warn, trip, por}
  localparam logic [6:0] PIN_SYNC_RST = 7'h08;
  // reset sequencer states
  typedef enum logic [2:0] {
    ST_POWER = 3'h0,
    ST_DELAY = 3'h1,
    ST_FAIL = 3'h2,
    ST_PIN = 3'h3,
    ST_PULSE = 3'h4,
    ST_RUN = 3'h5
  } scrs_state_type;
endpackage

// ===== design/scrs_sync.sv
// three-stage pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ns
module scrs_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // synchroniser stages; stage one feeds only stage two
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // agreed value
  logic [W-1:0] q_r;
  // shift chain and agreement filter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q_r <= RST_VAL;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end
  end
  assign q_o = q_r;
endmodule

// ===== design/scrs_clkmon.sv
// clock-loss detector: times out when the watched clock level stops changing
`timescale 1ns/1ns
module scrs_clkmon #(
  parameter int unsigned LIMIT = scrs_pkg::CLK_LOSS_CYC,
  parameter int unsigned CNT_W = 11
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic sclk_i,
  output logic timeout_o
);
  // last seen level of the watched clock
  logic prev_r;
  // cycles since the last edge
  logic [CNT_W-1:0] cnt_r;
  // one-cycle timeout pulse
  logic to_r;
  // edge seen on the watched clock
  logic edge_w;
  // count has reached the limit
  logic full_w;
  assign edge_w = sclk_i ^ prev_r;
  assign full_w = (cnt_r == CNT_W'(LIMIT - 1));
  // each edge retriggers the one-shot; disabled detector stays cleared
  // retrigger and timeout
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      to_r <= 1'b0;
    end else if (ce_i) begin
      prev_r <= sclk_i;
      to_r <= en_i & ~edge_w & full_w;
      if (!en_i || edge_w || full_w) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end
  assign timeout_o = to_r;
endmodule

// ===== dv/scrs_supply_model.sv
// far-side model: supply comparators, open-drain reset wire with pull-up, watched clock
`timescale 1ns/1ns
module scrs_supply_model (
  input wire logic clk_i,
  input wire logic pin_val_i,
  input wire logic pin_oe_i,
  input wire logic [2:0] sup_i,
  input wire logic ext_low_i,
  input wire logic clk_run_i,
  output logic por_ok_o,
  output logic trip_ok_o,
  output logic warn_ok_o,
  output logic pin_lvl_o,
  output logic sysclk_o
);
  // comparator levels: {battery ok, above trip, above warning}
  assign por_ok_o = sup_i[2];
  assign trip_ok_o = sup_i[1];
  assign warn_ok_o = sup_i[0];
  // external pull-low
  // wire is low if either party pulls it, else the pull-up wins
  assign pin_lvl_o = !((pin_oe_i && !pin_val_i) || ext_low_i);
  // watched clock changes every fourth cycle so each level outlasts the pin filter;
  // a level that flips every cycle never lets stages two and three agree
  logic [1:0] div_r;
  initial div_r = 2'h0;
  initial sysclk_o = 1'b0;
  // moves on the rising edge so the stop command from the bench never races it
  always @(posedge clk_i) begin
    if (clk_run_i) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
        sysclk_o <= !sysclk_o;
      end
    end
  end
endmodule

// ===== dv/scrs_top_tb.sv
// self-checking bench for the reset-source sequencer
`timescale 1ns/1ns
module scrs_top_tb;
  // short power-up delays keep the run brief
  localparam int DLY0 = 20;
  localparam int STEP = 10;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sleep_i = 1'b0;
  logic suspend_i = 1'b0;
  logic flash_wr_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  // far-side commands
  logic [2:0] sup = 3'h3;
  logic ext_low = 1'b0;
  logic clk_run = 1'b1;
  logic por_ok, trip_ok, warn_ok, pin_lvl, sysclk;
  logic [7:0] rdata;
  logic core_rst_o, rst_pin_o, rst_pin_oe_o, ram_invalid_o, supply_warn_o;
  logic [15:0] fetch_addr_o;
  int n_fail = 0;
  int n_checks = 0;
  int n;

  scrs_top #(.POR_DLY_LO_CYC(DLY0), .POR_DLY_MID_CYC(DLY0 + STEP),
    .POR_DLY_HI_CYC(DLY0 + 2 * STEP), .DLY_W(18)) scrs_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .por_ok_i(por_ok),
    .trip_ok_i(trip_ok), .warn_ok_i(warn_ok), .rst_pin_i(pin_lvl),
    .sysclk_i(sysclk), .por_dly_sel_i(sel), .sleep_i(sleep_i),
    .suspend_i(suspend_i), .flash_wr_i(flash_wr_i), .sfr_addr_i(addr),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .core_rst_o(core_rst_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .ram_invalid_o(ram_invalid_o), .supply_warn_o(supply_warn_o),
    .fetch_addr_o(fetch_addr_o));

  scrs_supply_model scrs_supply_model_inst (
    .clk_i(clk_i), .pin_val_i(rst_pin_o), .pin_oe_i(rst_pin_oe_o), .sup_i(sup),
    .ext_low_i(ext_low), .clk_run_i(clk_run), .por_ok_o(por_ok),
    .trip_ok_o(trip_ok), .warn_ok_o(warn_ok), .pin_lvl_o(pin_lvl),
    .sysclk_o(sysclk));

  // 10 MHz system clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // verdict and end of run
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // compare seen against expected
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int c);
    repeat (c) @(negedge clk_i);
  endtask

  // register write, strobe held one cycle
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask

  // register read, data registered one cycle after the address
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr = a;
    @(negedge clk_i);
    chk(16'(rdata), 16'(exp));
  endtask

  // bounded wait for the core reset level, cycles counted in c
  task wait_rst(input logic v, input int max, output int c);
    c = 0;
    while (core_rst_o !== v) begin
      if (c == max) begin
        chk(16'(core_rst_o), 16'(v));
        wrap_up;
      end
      @(negedge clk_i);
      c++;
    end
  endtask

  // power-up hold and delay for every supply-level selection
  task t_power;
    chk(16'({core_rst_o, rst_pin_oe_o, rst_pin_o}), 16'h6);
    for (int i = 0; i < 3; i++) begin
      sel = 2'(i);
      sup = 3'h3;
      cyc(8);
      chk(16'({core_rst_o, rst_pin_oe_o}), 16'h3);
      sup = 3'h7;
      wait_rst(1'b0, 80, n);
      chk(16'(n >= DLY0 + STEP * i && n <= DLY0 + STEP * i + 8), 16'h1);
    end
    chk(16'(ram_invalid_o), 16'h1);
    chk(fetch_addr_o, 16'h0000);
    rchk(8'hEF, 8'h02);
    rchk(8'hFF, 8'hE0);
    $display("test power done");
  endtask

  // external pin reset, optionally while asleep
  task t_pin(input logic slp);
    sleep_i = slp;
    ext_low = 1'b1;
    wait_rst(1'b1, 8, n);
    chk(16'(rst_pin_oe_o), 16'h0);
    ext_low = 1'b0;
    wait_rst(1'b0, 12, n);
    sleep_i = 1'b0;
    rchk(8'hEF, 8'h01);
    chk(16'(ram_invalid_o), 16'h0);
    $display("test pin done");
  endtask

  // supply-monitor reset and release without extra delay
  task t_fail;
    sup = 3'h5;
    wait_rst(1'b1, 8, n);
    cyc(10);
    chk(16'({core_rst_o, rst_pin_oe_o}), 16'h3);
    sup = 3'h7;
    wait_rst(1'b0, 10, n);
    rchk(8'hEF, 8'h02);
    chk(16'(ram_invalid_o), 16'h1);
    rchk(8'hFF, 8'hE0);
    $display("test fail done");
  endtask

  // early warning level
  task t_warn;
    sup = 3'h6;
    cyc(6);
    chk(16'(supply_warn_o), 16'h1);
    rchk(8'hFF, 8'hC0);
    sup = 3'h7;
    cyc(6);
    chk(16'(supply_warn_o), 16'h0);
    rchk(8'hFF, 8'hE0);
    $display("test warn done");
  endtask

  // sleep masks the monitor reset, wake restores it
  task t_sleep;
    sleep_i = 1'b1;
    sup = 3'h5;
    cyc(20);
    chk(16'(core_rst_o), 16'h0);
    sup = 3'h7;
    cyc(6);
    sleep_i = 1'b0;
    cyc(2);
    sup = 3'h5;
    wait_rst(1'b1, 8, n);
    sup = 3'h7;
    wait_rst(1'b0, 10, n);
    $display("test sleep done");
  endtask

  // monitor switched off: no supply reset, flash write resets, setting survives
  task t_monoff;
    wr(8'hFF, 8'h00);
    wr(8'hEF, 8'h02);
    sup = 3'h5;
    cyc(20);
    chk(16'(core_rst_o), 16'h0);
    sup = 3'h7;
    cyc(6);
    flash_wr_i = 1'b1;
    cyc(1);
    flash_wr_i = 1'b0;
    wait_rst(1'b1, 4, n);
    wait_rst(1'b0, 20, n);
    rchk(8'hEF, 8'h40);
    rchk(8'hFF, 8'h60);
    wr(8'hFF, 8'h80);
    wr(8'hEF, 8'h02);
    wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h00);
    rchk(8'hFF, 8'hE0);
    flash_wr_i = 1'b1;
    cyc(1);
    flash_wr_i = 1'b0;
    cyc(12);
    chk(16'(core_rst_o), 16'h0);
    $display("test monoff done");
  endtask

  // clock-loss detector: masked in suspend, fires after the timeout
  task t_clkloss;
    wr(8'hEF, 8'h06);
    suspend_i = 1'b1;
    clk_run = 1'b0;
    cyc(1100);
    chk(16'(core_rst_o), 16'h0);
    clk_run = 1'b1;
    suspend_i = 1'b0;
    cyc(4);
    clk_run = 1'b0;
    wait_rst(1'b1, 1020, n);
    chk(16'(n >= 1000 && n <= 1015), 16'h1);
    chk(16'(rst_pin_oe_o), 16'h0);
    clk_run = 1'b1;
    wait_rst(1'b0, 20, n);
    rchk(8'hEF, 8'h04);
    chk(fetch_addr_o, 16'h0000);
    wr(8'hEF, 8'h02);
    $display("test clkloss done");
  endtask

  // main sequence: 12-cycle reset with the battery low, then scenarios
  initial begin
    cyc(12);
    rst_b_i = 1'b1;
    cyc(2);
    t_power;
    t_pin(1'b0);
    t_pin(1'b1);
    t_fail;
    t_warn;
    t_sleep;
    t_monoff;
    t_clkloss;
    wrap_up;
  end
endmodule
